// >>> rtl/odsi_host.sv
// host end: ahb-lite slave that queues frames and shifts them out
// assumes a single ahb-lite master, word accesses only
`timescale 1ns/100ps
module odsi_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    odsi_link_if.host link
);
    typedef enum logic [1:0] {
        ODSI_H_IDLE = 2'b00,
        ODSI_H_SHIFT = 2'b01,
        ODSI_H_GAP = 2'b10
    } odsi_hstate_t;
    // the divider and gap counters are 4 and 5 bits; the far end needs 3 hclk per half period
    if (odsi_pkg::SCLK_HALF < 3 || odsi_pkg::SCLK_HALF > 16 || odsi_pkg::GAP_CYC > 31) begin : g_bad_timing
        $error("link clock half period or frame gap out of range");
    end
    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic hold_q;
    logic [31:0] rdata_q;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [31:0] f_out_data;
    logic push;
    odsi_hstate_t st_q;
    logic fifo_wait;
    assign fifo_wait = wr_pend_q && addr_q == odsi_pkg::REG_FRAME && !f_in_ready;
    assign push = wr_pend_q && addr_q == odsi_pkg::REG_FRAME && f_in_ready;
    assign hreadyout = !fifo_wait;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hreadyout) begin
            wr_pend_q <= hsel && htrans[1] && hwrite && hready;
            rd_pend_q <= hsel && htrans[1] && !hwrite && hready;
            addr_q <= haddr;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= 1'b0;
        end else if (wr_pend_q && addr_q == odsi_pkg::REG_CTRL) begin
            hold_q <= hwdata[odsi_pkg::CTRL_HOLD];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h00000000;
        end else if (hsel && htrans[1] && !hwrite && hready && hreadyout) begin
            case (haddr)
                odsi_pkg::REG_STATUS: rdata_q <= {29'h0, !f_out_valid, !f_in_ready, st_q != ODSI_H_IDLE};
                odsi_pkg::REG_CTRL: rdata_q <= {31'h0, hold_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end
    end
    // ----------------------------------------
    // frame queue
    // ----------------------------------------
    odsi_fifo #(.WIDTH(32), .DEPTH(8)) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(push),
        .in_ready(f_in_ready),
        .in_data(hwdata),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );
    // ----------------------------------------
    // serial shifter
    // ----------------------------------------
    logic [31:0] sh_q;
    logic [5:0] bit_q;
    logic [3:0] div_q;
    logic [4:0] gap_q;
    logic sync_n_q;
    logic sclk_q;
    logic sdin_q;
    assign f_out_ready = st_q == ODSI_H_IDLE && !hold_q;
    assign link.sync_n = sync_n_q;
    assign link.sclk = sclk_q;
    assign link.sdin = sdin_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ODSI_H_IDLE;
            sh_q <= 32'h00000000;
            bit_q <= 6'h00;
            div_q <= 4'h0;
            gap_q <= 5'h00;
            sync_n_q <= 1'b1;
            // idle high from reset on, so the far end never sees a stray falling edge
            sclk_q <= 1'b1;
            sdin_q <= 1'b0;
        end else begin
            case (st_q)
                ODSI_H_IDLE: begin
                    if (f_out_valid && !hold_q) begin
                        // frame select falls first, msb set up with it, top bit forced low
                        sh_q <= {1'b0, f_out_data[30:0]} << 1;
                        sdin_q <= 1'b0;
                        sync_n_q <= 1'b0;
                        sclk_q <= 1'b1;
                        bit_q <= 6'h00;
                        div_q <= 4'h0;
                        st_q <= ODSI_H_SHIFT;
                    end
                end
                ODSI_H_SHIFT: begin
                    if (div_q == 4'(odsi_pkg::SCLK_HALF - 1)) begin
                        div_q <= 4'h0;
                        sclk_q <= !sclk_q;
                        if (sclk_q) begin
                            // device samples here on the falling edge
                            bit_q <= bit_q + 6'h01;
                        end else if (bit_q == 6'(odsi_pkg::FRAME_BITS)) begin
                            sync_n_q <= 1'b1;
                            gap_q <= 5'h00;
                            st_q <= ODSI_H_GAP;
                        end else begin
                            sdin_q <= sh_q[31];
                            sh_q <= sh_q << 1;
                        end
                    end else begin
                        div_q <= div_q + 4'h1;
                    end
                end
                ODSI_H_GAP: begin
                    sclk_q <= 1'b1;
                    // minimum delay before the next frame select edge
                    if (gap_q == 5'(odsi_pkg::GAP_CYC)) begin
                        st_q <= ODSI_H_IDLE;
                    end else begin
                        gap_q <= gap_q + 5'h01;
                    end
                end
                default: st_q <= ODSI_H_IDLE;
            endcase
        end
    end
endmodule

// >>> rtl/odsi_pkg.sv
// package for the octal dac serial front end and its host controller
// assumes one hclk domain of 25 mhz on both ends
package odsi_pkg;
    localparam int FRAME_BITS = 32;
    localparam int PREFIX_MSB = 31;
    localparam int CMD_MSB = 27;
    localparam int CMD_LSB = 24;
    localparam int ADDR_MSB = 23;
    localparam int ADDR_LSB = 20;
    localparam int DATA_MSB = 19;
    localparam int DATA_LSB = 4;
    localparam int FEAT_MSB = 3;
    localparam int CHANNELS = 8;
    localparam logic [3:0] CMD_WRITE_INPUT = 4'h0;
    localparam logic [3:0] ADDR_BROADCAST = 4'hf;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    // link clock period in ns and the divider half period derived from hclk
    localparam int HCLK_NS = 40;
    localparam int SCLK_NS = 320;
    localparam int SCLK_HALF = SCLK_NS / (2 * HCLK_NS);
    // gap from last falling edge to next frame select, ns
    localparam int GAP_NS = 400;
    localparam int GAP_CYC = (GAP_NS + HCLK_NS - 1) / HCLK_NS;
    // host register offsets
    localparam logic [7:0] REG_FRAME = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam int STAT_BUSY = 0;
    localparam int STAT_FULL = 1;
    localparam int STAT_EMPTY = 2;
    localparam int CTRL_HOLD = 0;
endpackage

// >>> rtl/odsi_link_if.sv
// three-wire link between host controller and dac front end
// assumes the bench supplies no extra drivers
`timescale 1ns/100ps
interface odsi_link_if;
    logic sync_n;
    logic sclk;
    logic sdin;
    modport host (output sync_n, output sclk, output sdin);
    modport dev (input sync_n, input sclk, input sdin);
endinterface

// >>> rtl/odsi_fifo.sv
// flip-flop fifo with valid and ready on both sides
// assumes a single clock domain
`timescale 1ns/100ps
module odsi_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // pointers carry one wrap bit, so only powers of two keep full and empty apart
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
        $error("fifo depth must be a power of two and width at least one");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge hclk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + (AW+1)'(1);
            if (pop) rd_q <= rd_q + (AW+1)'(1);
        end
    end
endmodule

// >>> rtl/odsi_dev.sv
// device end: 32-bit serial input front end of an eight channel dac
// assumes the link pins are asynchronous to hclk and sclk is slow against hclk
`timescale 1ns/100ps
// Notes on behaviour
// - 32-bit frame: prefix, command, data, feature
// - low bits below resolution are ignored
// - host sends msb first, top bit zero
// - only first 32 bits are captured
// - command code taken from bits 27..24
// - bits 23..20 select the channel
// - data is left-aligned straight binary
// - host lowers frame select before data
// - one bit sampled per falling sclk
// - register frozen after 32nd falling edge
// - execute right after 32nd edge
// - new frame only on select falling edge
// - early select rise discards the frame
// - host waits minimum gap between frames
// - command zero writes addressed channel register
// - address all ones broadcasts, others invalid
// - frames with top bit set are ignored; here they write no channel but still pulse exec_pulse and set last_cmd
module odsi_dev #(
    parameter int RES_BITS = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    odsi_link_if.dev link,
    output logic [odsi_pkg::CHANNELS*16-1:0] chan_data,
    output logic [odsi_pkg::CHANNELS-1:0] chan_wr,
    output logic exec_pulse,
    output logic [3:0] last_cmd,
    output logic [3:0] last_feature,
    output logic frame_abort
);
    if (RES_BITS != 12 && RES_BITS != 14 && RES_BITS != 16) begin : g_bad_res
        $error("resolution must be 12, 14 or 16");
    end
    // ----------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------
    logic [2:0] sync_s_q;
    logic [2:0] sclk_s_q;
    logic [1:0] din_s_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_s_q <= 3'h7;
            sclk_s_q <= 3'h7;
            din_s_q <= 2'h0;
        end else begin
            sync_s_q <= {sync_s_q[1:0], link.sync_n};
            sclk_s_q <= {sclk_s_q[1:0], link.sclk};
            din_s_q <= {din_s_q[0], link.sdin};
        end
    end
    logic sync_fall;
    logic sync_rise;
    logic sclk_fall;
    assign sync_fall = sync_s_q[2] && !sync_s_q[1];
    assign sync_rise = !sync_s_q[2] && sync_s_q[1];
    assign sclk_fall = sclk_s_q[2] && !sclk_s_q[1];
    // ----------------------------------------
    // shift register and bit counter
    // ----------------------------------------
    logic [31:0] sr_q;
    logic [5:0] cnt_q;
    logic armed_q;
    logic exec_q;
    logic abort_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sr_q <= 32'h00000000;
            cnt_q <= 6'h00;
            armed_q <= 1'b0;
            exec_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            exec_q <= 1'b0;
            abort_q <= 1'b0;
            if (sync_fall) begin
                cnt_q <= 6'h00;
                armed_q <= 1'b1;
            end else if (sync_rise && armed_q && cnt_q < 6'h1f) begin
                armed_q <= 1'b0;
                cnt_q <= 6'h00;
                abort_q <= 1'b1;
            end else if (armed_q && sclk_fall && !sync_s_q[1]) begin
                sr_q <= {sr_q[30:0], din_s_q[1]};
                cnt_q <= cnt_q + 6'h01;
                if (cnt_q == 6'(odsi_pkg::FRAME_BITS - 1)) begin
                    // freeze until the next select fall
                    armed_q <= 1'b0;
                    exec_q <= 1'b1;
                end
            end
        end
    end
    // ----------------------------------------
    // decode and channel registers
    // ----------------------------------------
    function automatic logic [15:0] odsi_mask(input logic [15:0] d);
        // drop bits below the part's resolution, data stays left aligned
        odsi_mask = d & ~16'((17'h1 << (16 - RES_BITS)) - 17'h1);
    endfunction
    logic [3:0] cmd;
    logic [3:0] addr;
    logic valid_wr;
    assign cmd = sr_q[odsi_pkg::CMD_MSB:odsi_pkg::CMD_LSB];
    assign addr = sr_q[odsi_pkg::ADDR_MSB:odsi_pkg::ADDR_LSB];
    assign valid_wr = exec_q && !sr_q[odsi_pkg::PREFIX_MSB] && cmd == odsi_pkg::CMD_WRITE_INPUT;
    logic [odsi_pkg::CHANNELS-1:0] wr_q;
    genvar gi;
    generate
        for (gi = 0; gi < odsi_pkg::CHANNELS; gi++) begin : g_ch
            logic hit;
            // direct address or broadcast; other high addresses hit nothing
            assign hit = valid_wr && (addr == 4'(gi) || addr == odsi_pkg::ADDR_BROADCAST);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    chan_data[gi*16 +: 16] <= odsi_pkg::DATA_RESET;
                    wr_q[gi] <= 1'b0;
                end else begin
                    wr_q[gi] <= hit;
                    if (hit) chan_data[gi*16 +: 16] <= odsi_mask(sr_q[odsi_pkg::DATA_MSB:odsi_pkg::DATA_LSB]);
                end
            end
        end
    endgenerate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exec_pulse <= 1'b0;
            last_cmd <= 4'h0;
            last_feature <= 4'h0;
            frame_abort <= 1'b0;
        end else begin
            exec_pulse <= exec_q;
            frame_abort <= abort_q;
            if (exec_q) begin
                last_cmd <= cmd;
                last_feature <= sr_q[odsi_pkg::FEAT_MSB:0];
            end
        end
    end
    assign chan_wr = wr_q;
endmodule

// >>> bench/odsi_sva.sv
// checker on the link between host end and dac front end, plus the front end's execute outputs
// assumes one hclk domain and link pins that move just after hclk edges
`timescale 1ns/100ps
module odsi_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic sdin,
    input wire logic exec_pulse,
    input wire logic [7:0] chan_wr
);
    logic [5:0] fall_q;
    logic [7:0] gap_q;
    // ---------------
    // helper counters
    // ---------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fall_q <= 6'h0;
        end else if ($fell(sync_n)) begin
            fall_q <= 6'h0;
        end else if ($fell(sclk) && !sync_n) begin
            fall_q <= fall_q + 6'h1;
        end
    end
    // saturates, so the first frame after reset never looks short
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_q <= 8'hff;
        end else if ($fell(sclk) && !sync_n) begin
            gap_q <= 8'h0;
        end else if (gap_q != 8'hff) begin
            gap_q <= gap_q + 8'h1;
        end
    end
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_first_zero;
        $fell(sclk) && !sync_n && fall_q == 6'h0 |-> !sdin;
    endproperty
    a_first_zero: assert property (p_first_zero) else $error("first frame bit not zero");
    property p_fall_framed;
        $fell(sclk) |-> !sync_n;
    endproperty
    a_fall_framed: assert property (p_fall_framed) else $error("shift edge outside frame");
    property p_rise_count;
        $rose(sync_n) |-> fall_q == 6'h20;
    endproperty
    a_rise_count: assert property (p_rise_count) else $error("frame not 32 edges");
    property p_gap;
        $fell(sync_n) |-> gap_q >= odsi_pkg::GAP_CYC;
    endproperty
    a_gap: assert property (p_gap) else $error("frame gap too short");
    property p_exec_due;
        $fell(sclk) && !sync_n && fall_q == 6'h1f |-> ##[1:8] exec_pulse;
    endproperty
    a_exec_due: assert property (p_exec_due) else $error("no execute after last bit");
    property p_exec_count;
        exec_pulse |-> fall_q == 6'h20;
    endproperty
    a_exec_count: assert property (p_exec_count) else $error("execute without full frame");
    property p_exec_once;
        exec_pulse |=> !exec_pulse;
    endproperty
    a_exec_once: assert property (p_exec_once) else $error("execute longer than one cycle");
    property p_wr_shape;
        chan_wr != 8'h00 |-> exec_pulse && ($onehot(chan_wr) || chan_wr == 8'hff);
    endproperty
    a_wr_shape: assert property (p_wr_shape) else $error("bad channel write");
endmodule

// >>> bench/test_octal_dac_serial_input.sv
// bench: ahb host end drives front end one; front end two (12 bit) is driven by hand with faults
// assumes odsi_pkg, the link interface and all design modules are compiled first
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t %h %h", $time, a, b); end end
module test_octal_dac_serial_input;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ex1, ex2, ab2, sclk_q, sync_q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] cmd1, ft1;
    logic [5:0] mon_n;
    logic [7:0] haddr, wr1;
    logic [31:0] hwdata, hrdata, rd, seed, mon_w, f;
    logic [31:0] fq [8];
    logic [15:0] model [8];
    logic [127:0] cd1, cd2, cd3;
    int err_total, checks, n_ex2, n_ab2;
    localparam logic [31:0] CF [4] = '{32'h00fffff1, 32'h00912340, 32'h03255551, 32'h80712346};
    odsi_link_if u_if1 ();
    odsi_link_if u_if2 ();
    odsi_host u_odsi_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(u_if1.host));
    odsi_dev u_odsi_dev (.hclk(hclk), .hresetn(hresetn), .link(u_if1.dev), .chan_data(cd1), .chan_wr(wr1),
        .exec_pulse(ex1), .last_cmd(cmd1), .last_feature(ft1), .frame_abort());
    odsi_dev #(.RES_BITS(12)) u_odsi_dev2 (.hclk(hclk), .hresetn(hresetn), .link(u_if2.dev), .chan_data(cd2),
        .chan_wr(), .exec_pulse(ex2), .last_cmd(), .last_feature(), .frame_abort(ab2));
    odsi_dev #(.RES_BITS(14)) u_odsi_dev3 (.hclk(hclk), .hresetn(hresetn), .link(u_if2.dev), .chan_data(cd3),
        .chan_wr(), .exec_pulse(), .last_cmd(), .last_feature(), .frame_abort());
    odsi_sva u_odsi_sva (.hclk(hclk), .hresetn(hresetn), .sync_n(u_if1.sync_n), .sclk(u_if1.sclk),
        .sdin(u_if1.sdin), .exec_pulse(ex1), .chan_wr(wr1));
    // -------------------
    // helpers and drivers
    // -------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic void apply(input logic [31:0] w);
        for (int i = 0; i < 8; i++) begin
            if (w[27:24] == 4'h0 && (w[23:20] == 4'hf || w[23:20] == 4'(i))) model[i] = w[19:4];
        end
    endfunction
    function automatic logic [127:0] pack();
        logic [127:0] v;
        for (int i = 0; i < 8; i++) v[i*16 +: 16] = model[i];
        return v;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wait_for(input bit ex);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while ((ex ? ex1 : hreadyout) !== 1'b1 && n < 4000);
        if ((ex ? ex1 : hreadyout) !== 1'b1) begin
            err_total++;
            stop_test();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_for(1'b0);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_for(1'b0);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask
    task automatic expect_frame(input logic [31:0] w);
        apply(w);
        wait_for(1'b1);
        `CHK(cd1, pack())
        `CHK(cmd1, w[27:24])
        `CHK(ft1, w[3:0])
        `CHK(mon_w, {1'b0, w[30:0]})
        `CHK(mon_n, 6'h20)
    endtask
    // hand driver: 320 ns link clock, msb first, released data line shows the inverse of its last bit
    task automatic send2(input logic [35:0] bits, input int n);
        u_if2.sync_n <= 1'b0;
        for (int i = 35; i > 35 - n; i--) begin
            u_if2.sclk <= 1'b1;
            u_if2.sdin <= bits[i];
            repeat (4) @(posedge hclk);
            u_if2.sclk <= 1'b0;
            repeat (4) @(posedge hclk);
        end
        u_if2.sync_n <= 1'b1;
        u_if2.sdin <= ~bits[36-n];
        repeat (16) @(posedge hclk);
    endtask
    // -----------------
    // clock and monitor
    // -----------------
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        sclk_q <= u_if1.sclk;
        sync_q <= u_if1.sync_n;
        if (sync_q && !u_if1.sync_n) begin
            mon_n <= 6'h0;
        end else if (!u_if1.sync_n && sclk_q && !u_if1.sclk) begin
            mon_w <= {mon_w[30:0], u_if1.sdin};
            mon_n <= mon_n + 6'h1;
        end
        n_ex2 <= n_ex2 + int'(ex2);
        n_ab2 <= n_ab2 + int'(ab2);
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, mon_w, mon_n} = '0;
        hsize = 3'h2;
        {u_if2.sync_n, u_if2.sclk, u_if2.sdin} = 3'h6;
        {sclk_q, sync_q} = 2'h3;
        seed = 32'h0000004e;
        {err_total, checks, n_ex2, n_ab2} = '0;
        for (int i = 0; i < 8; i++) model[i] = 16'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        `CHK(cd1, 128'h0)
        bus(1'b0, odsi_pkg::REG_STATUS, 32'h0);
        `CHK(rd[2:0], 3'h4)
        bus(1'b0, 8'h0c, 32'h0);
        `CHK(rd, 32'h0)
        $display("test registers done");
        for (int i = 0; i < 28; i++) begin
            f = (i < 4) ? CF[i] : rnd();
            if (i >= 4 && i < 12) f[27:20] = {4'h0, 4'(i - 4)};
            bus(1'b1, odsi_pkg::REG_FRAME, f);
            expect_frame(f);
        end
        $display("test frames done");
        bus(1'b1, odsi_pkg::REG_CTRL, 32'h1);
        bus(1'b0, odsi_pkg::REG_CTRL, 32'h0);
        `CHK(rd[0], 1'b1)
        for (int i = 0; i < 8; i++) begin
            fq[i] = rnd();
            bus(1'b1, odsi_pkg::REG_FRAME, fq[i]);
        end
        bus(1'b0, odsi_pkg::REG_STATUS, 32'h0);
        `CHK(rd[2:0], 3'h2)
        bus(1'b1, odsi_pkg::REG_CTRL, 32'h0);
        for (int i = 0; i < 8; i++) expect_frame(fq[i]);
        bus(1'b0, odsi_pkg::REG_STATUS, 32'h0);
        `CHK(rd[2], 1'b1)
        $display("test buffer done");
        send2({32'h0037777f, 4'h0}, 20);
        `CHK(n_ab2, 1)
        `CHK(cd2[63:48], 16'h0)
        send2({32'h002abcd5, 4'hf}, 36);
        `CHK(cd2[47:32], 16'habc0)
        `CHK(cd3[47:32], 16'habcc)
        send2({32'h003fff00, 4'h0}, 32);
        `CHK(cd2[63:48], 16'hfff0)
        `CHK(cd3[63:48], 16'hfff0)
        `CHK(n_ex2, 2)
        send2({32'h80455555, 4'h0}, 32);
        `CHK(cd2[79:64], 16'h0)
        $display("test link faults done");
        stop_test();
    end
endmodule
